// [hdl/data_address_pointer_regs.sv]
// Temporary registers, extended pointers and circular start registers
`timescale 1ns/1ps
`include "dap_regs.svh"

// Overview of operation
// - Four 16-bit temporary registers for multiplicands, shift counts and transition metrics.
// - In legacy compatibility mode temporary register 2 mirrors the shift-mode field.
// - Swap exchanges an auxiliary pointer low part with a temporary register.
// - Eight 23-bit auxiliary pointers, 7-bit page over 16-bit low part.
// - Pointer arithmetic uses all 23 bits, carrying across page boundaries.
// - Stack, I/O, register-bit and direct modes keep arithmetic in low 16 bits.
// - Auxiliary low parts are instruction and memory-mapped; page only via full pointer.
// - Full auxiliary pointers are instruction-only, never memory-mapped.
// - Address-unit ALU works on low parts alongside address-generator updates.
// - Coefficient pointer is 7-bit page concatenated with 16-bit low part.
// - Coefficient page is memory-mapped or via full pointer; low part both ways.
// - Full coefficient pointer is instruction-only, never memory-mapped.
// - Coefficient pointer usable in any slot, including third dual-MAC operand.
// - Five 16-bit circular start registers with no alignment constraint.
// - Start registers serve pointers 0/1, 2/3, 4/5, 6/7 and coefficient.
// - Start address is added only when status register 2 marks pointer circular.
// - Circular address is own page with low part plus start, 16-bit sum.
// - Memory-mapped coefficient page occupies bits 6 to 0.
// - Start registers sit at words 32h through 36h.
module data_address_pointer_regs #(
  parameter int AUX_COUNT  = 8,
  parameter int TEMP_COUNT = 4,
  parameter int AGEN_COUNT = 3
) (
  // Clock and reset
  input  wire logic                                   sys_clk,
  input  wire logic                                   rst,
  // Instruction-side writes and operations
  input  wire dap_pkg::ext_wr_t                       ext_wr,
  input  wire dap_pkg::low_wr_t                       low_wr,
  input  wire dap_pkg::tmp_wr_t                       tmp_wr,
  input  wire dap_pkg::swap_t                         swap_req,
  input  wire dap_pkg::alu_req_t                      alu_req,
  input  wire dap_pkg::dag_req_t                      dag_req,
  // Memory-mapped access
  input  wire dap_pkg::mmr_req_t                      mmr_req,
  output logic      [`WORD_W-1:0]                     mmr_rdata_ff,
  output logic                                        mmr_hit_ff,
  // Status register fields
  input  wire logic                                   legacy_compat_mode,
  input  wire logic [`ASM_W-1:0]                      acc_shift_mode_field,
  input  wire logic [AUX_COUNT:0]                     circ_cfg,
  output logic                                        asm_wr_ff,
  output logic      [`ASM_W-1:0]                      asm_wdata_ff,
  // Operand address generation
  input  wire dap_pkg::agen_req_t [AGEN_COUNT-1:0]    agen_req,
  output logic      [AGEN_COUNT-1:0][`PTR_W-1:0]      agen_addr_ff,
  output logic      [AGEN_COUNT-1:0]                  agen_valid_ff,
  // Register contents
  output logic      [TEMP_COUNT-1:0][`WORD_W-1:0]     temp_regs_ff,
  output logic      [AUX_COUNT-1:0][`PTR_W-1:0]       ext_aux_ptr_ff,
  output logic      [`PTR_W-1:0]                      ext_coef_ptr_ff,
  output logic      [4:0][`WORD_W-1:0]                circ_start_ff
);
  import dap_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // Selector width, start-register pairing and swap index are sized for these
  if (AUX_COUNT != 8)
    $error("AUX_COUNT must be 8");
  if (TEMP_COUNT != 4)
    $error("TEMP_COUNT must be 4");
  if (AGEN_COUNT < 1 || AGEN_COUNT > 3)
    $error("AGEN_COUNT must be 1 to 3");

  // ************************************************************
  // Constants and storage
  // ************************************************************
  localparam int                 PTR_COUNT   = AUX_COUNT + 1;
  localparam int                 CIRC_COUNT  = 5;
  localparam logic [`MMR_AW-1:0] AUX_BASE    = `ADDR_AUX_LOW_BASE;
  localparam logic [`MMR_AW-1:0] TEMP_BASE   = `ADDR_TEMP_BASE;
  localparam logic [`MMR_AW-1:0] CIRC_BASE   = `ADDR_CIRC_START;
  localparam logic [`MMR_AW-1:0] COEF_LOW_A  = `ADDR_COEF_LOW;
  localparam logic [`MMR_AW-1:0] COEF_PAGE_A = `ADDR_COEF_PAGE;

  // Slot 8 of the pointer arrays is the coefficient pointer
  logic [`PAGE_W-1:0] ptr_page_ff [PTR_COUNT];
  logic [`WORD_W-1:0] ptr_low_ff  [PTR_COUNT];
  logic [`PAGE_W-1:0] nxt_page    [PTR_COUNT];
  logic [`WORD_W-1:0] nxt_low     [PTR_COUNT];
  logic [`WORD_W-1:0] nxt_temp    [TEMP_COUNT];
  logic [`WORD_W-1:0] nxt_circ    [CIRC_COUNT];

  // ************************************************************
  // Memory-mapped address decode
  // ************************************************************
  // Only low parts, temporary registers, the coefficient page and start registers decode;
  // full extended pointers have no address at all
  logic                 hit_aux_low;
  logic                 hit_temp;
  logic                 hit_coef_low;
  logic                 hit_coef_page;
  logic                 hit_circ;
  logic [`MMR_AW-1:0]   circ_off;
  logic                 hit_any;

  assign hit_aux_low   = mmr_req.addr[6:3] == AUX_BASE[6:3];
  assign hit_temp      = mmr_req.addr[6:2] == TEMP_BASE[6:2];
  assign hit_coef_low  = mmr_req.addr == COEF_LOW_A;
  assign hit_coef_page = mmr_req.addr == COEF_PAGE_A;
  assign circ_off      = mmr_req.addr - CIRC_BASE;
  assign hit_circ      = mmr_req.addr >= CIRC_BASE && circ_off < 7'(CIRC_COUNT);
  assign hit_any       = hit_aux_low | hit_temp | hit_coef_low | hit_coef_page | hit_circ;

  // ************************************************************
  // Address-unit ALU on auxiliary low parts
  // ************************************************************
  // Reads the stored low part, so it runs beside a generator update
  logic [`WORD_W-1:0] alu_src;
  logic [`WORD_W-1:0] alu_res;

  assign alu_src = ptr_low_ff[alu_req.ar];
  always_comb begin
    case (alu_req.op)
      ALU_ADD: alu_res = alu_src + alu_req.operand;
      ALU_SUB: alu_res = alu_src - alu_req.operand;
      ALU_AND: alu_res = alu_src & alu_req.operand;
      ALU_OR:  alu_res = alu_src | alu_req.operand;
      ALU_XOR: alu_res = alu_src ^ alu_req.operand;
      ALU_SHL: alu_res = alu_src << alu_req.operand[3:0];
      ALU_SHR: alu_res = alu_src >> alu_req.operand[3:0];
      default: alu_res = alu_src;
    endcase
  end

  // ************************************************************
  // Address-generator pointer step
  // ************************************************************
  // Sign-extended step; the full sum crosses pages, the low-only sum wraps
  logic [`PTR_W-1:0]  dag_ptr;
  logic [`PTR_W-1:0]  dag_full;
  logic [`WORD_W-1:0] dag_low;

  assign dag_ptr  = {ptr_page_ff[dag_req.sel], ptr_low_ff[dag_req.sel]};
  assign dag_full = dag_ptr + {{(`PTR_W-`WORD_W){dag_req.step[`LOW_MSB]}}, dag_req.step};
  assign dag_low  = dag_ptr[`LOW_MSB:0] + dag_req.step;

  // ************************************************************
  // Pointer next-state, one slot per pointer
  // ************************************************************
  // Priority rising: generator, ALU, memory write, swap, low write, full write
  for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
    localparam logic [`PTR_SEL_W-1:0] SEL = `PTR_SEL_W'(i);
    logic is_aux;
    logic mmr_low_wr;

    assign is_aux     = i < AUX_COUNT;
    assign mmr_low_wr = mmr_req.wr && (is_aux ? (hit_aux_low && mmr_req.addr[2:0] == 3'(i)) : hit_coef_low);

    // Hold by default; later sources win
    always_comb begin
      nxt_page[i] = ptr_page_ff[i];
      nxt_low[i]  = ptr_low_ff[i];
      if (dag_req.en && dag_req.sel == SEL) begin
        if (dag_req.low_only) begin
          nxt_low[i] = dag_low;
        end else begin
          nxt_page[i] = dag_full[`PAGE_MSB:`PAGE_LSB];
          nxt_low[i]  = dag_full[`LOW_MSB:0];
        end
      end
      if (is_aux && alu_req.en && alu_req.ar == 3'(i)) begin
        nxt_low[i] = alu_res;
      end
      if (mmr_low_wr) begin
        nxt_low[i] = mmr_req.wdata;
      end
      if (!is_aux && mmr_req.wr && hit_coef_page) begin
        nxt_page[i] = mmr_req.wdata[`COEF_PAGE_MSB:0];
      end
      if (is_aux && swap_req.en && swap_req.ar == 3'(i)) begin
        nxt_low[i] = temp_regs_ff[swap_req.t];
      end
      if (low_wr.en && low_wr.sel == SEL) begin
        nxt_low[i] = low_wr.data;
      end
      if (ext_wr.en && ext_wr.sel == SEL) begin
        nxt_page[i] = ext_wr.data[`PAGE_MSB:`PAGE_LSB];
        nxt_low[i]  = ext_wr.data[`LOW_MSB:0];
      end
    end

    // Page and low part move together on the same edge
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        ptr_page_ff[i] <= `PAGE_RST;
        ptr_low_ff[i]  <= `WORD_RST;
      end else begin
        ptr_page_ff[i] <= nxt_page[i];
        ptr_low_ff[i]  <= nxt_low[i];
      end
    end

    if (i < AUX_COUNT) begin : g_aux_out
      assign ext_aux_ptr_ff[i] = {ptr_page_ff[i], ptr_low_ff[i]};
    end else begin : g_coef_out
      assign ext_coef_ptr_ff = {ptr_page_ff[i], ptr_low_ff[i]};
    end
  end

  // ************************************************************
  // Temporary registers
  // ************************************************************
  // Shift-mode field sign-extended for the bound copy of register 2
  logic [`WORD_W-1:0] asm_ext;

  assign asm_ext = {{(`WORD_W-`ASM_W){acc_shift_mode_field[`ASM_W-1]}}, acc_shift_mode_field};

  for (genvar j = 0; j < TEMP_COUNT; j++) begin : g_temp
    // Compat mode overrides all writers of slot 2
    always_comb begin
      nxt_temp[j] = temp_regs_ff[j];
      if (mmr_req.wr && hit_temp && mmr_req.addr[1:0] == 2'(j)) begin
        nxt_temp[j] = mmr_req.wdata;
      end
      if (swap_req.en && swap_req.t == 2'(j)) begin
        nxt_temp[j] = ptr_low_ff[swap_req.ar];
      end
      if (tmp_wr.en && tmp_wr.idx == 2'(j)) begin
        nxt_temp[j] = tmp_wr.data;
      end
      if (j == 2 && legacy_compat_mode) begin
        nxt_temp[j] = asm_ext;
      end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        temp_regs_ff[j] <= `WORD_RST;
      end else begin
        temp_regs_ff[j] <= nxt_temp[j];
      end
    end
  end

  // ************************************************************
  // Writes aimed at temporary register 2 in compatibility mode
  // ************************************************************
  // Such writes land in the shift-mode field, not in the register
  logic               t2_by_instr;
  logic               t2_by_swap;
  logic               t2_by_mmr;
  logic               t2_wr;
  logic [`WORD_W-1:0] t2_val;

  assign t2_by_instr = tmp_wr.en && tmp_wr.idx == 2'd2;
  assign t2_by_swap  = swap_req.en && swap_req.t == 2'd2;
  assign t2_by_mmr   = mmr_req.wr && hit_temp && mmr_req.addr[1:0] == 2'd2;
  assign t2_wr       = legacy_compat_mode && (t2_by_instr || t2_by_swap || t2_by_mmr);
  assign t2_val      = t2_by_instr ? tmp_wr.data :
                       t2_by_swap  ? ptr_low_ff[swap_req.ar] : mmr_req.wdata;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      asm_wr_ff    <= 1'b0;
      asm_wdata_ff <= 5'h0;
    end else begin
      asm_wr_ff    <= t2_wr;
      asm_wdata_ff <= t2_wr ? t2_val[`ASM_W-1:0] : asm_wdata_ff;
    end
  end

  // ************************************************************
  // Circular start registers
  // ************************************************************
  // Any 16-bit value is taken; no alignment is enforced
  for (genvar k = 0; k < CIRC_COUNT; k++) begin : g_circ
    assign nxt_circ[k] = (mmr_req.wr && hit_circ && circ_off == 7'(k)) ? mmr_req.wdata
                                                                        : circ_start_ff[k];
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        circ_start_ff[k] <= `WORD_RST;
      end else begin
        circ_start_ff[k] <= nxt_circ[k];
      end
    end
  end

  // ************************************************************
  // Memory-mapped read path
  // ************************************************************
  // Unmapped words read as zero with the hit flag low
  logic [`WORD_W-1:0] nxt_rdata;

  assign nxt_rdata = hit_aux_low   ? ptr_low_ff[mmr_req.addr[2:0]] :
                     hit_coef_low  ? ptr_low_ff[AUX_COUNT] :
                     hit_coef_page ? {9'h000, ptr_page_ff[AUX_COUNT]} :
                     hit_temp      ? temp_regs_ff[mmr_req.addr[1:0]] :
                     hit_circ      ? circ_start_ff[circ_off[2:0]] : `WORD_RST;

  // Writes leave the held read word alone
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mmr_rdata_ff <= `WORD_RST;
      mmr_hit_ff   <= 1'b0;
    end else begin
      mmr_rdata_ff <= mmr_req.rd ? nxt_rdata : mmr_rdata_ff;
      mmr_hit_ff   <= mmr_req.rd && hit_any;
    end
  end

  // ************************************************************
  // Operand address generators
  // ************************************************************
  // Pointers 2n and 2n+1 share start register n; the coefficient uses the fifth
  for (genvar a = 0; a < AGEN_COUNT; a++) begin : g_agen
    logic               sel_coef;
    logic [2:0]         circ_idx;
    logic [`WORD_W-1:0] start_sel;
    logic [`PTR_W-1:0]  ptr_sel;
    logic [3:0]         sel_c;

    assign sel_coef  = agen_req[a].sel >= `COEF_SEL;
    assign sel_c     = sel_coef ? `COEF_SEL : agen_req[a].sel;
    assign circ_idx  = sel_coef ? `CIRC_COEF_IDX : agen_req[a].sel[3:1];
    assign start_sel = circ_start_ff[circ_idx];
    assign ptr_sel   = {ptr_page_ff[sel_c], ptr_low_ff[sel_c]};

    // One generator per operand slot
    ptr_addr_gen u_gen (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .req      (agen_req[a].en),
      .ptr      (ptr_sel),
      .start    (start_sel),
      .circ     (circ_cfg[sel_c]),
      .addr_ff  (agen_addr_ff[a]),
      .valid_ff (agen_valid_ff[a])
    );
  end

endmodule : data_address_pointer_regs

// [hdl/dap_regs.svh]
// Offsets, field positions, reset values and widths of the pointer register file
`ifndef DAP_REGS_SVH
`define DAP_REGS_SVH

// ************************************************************
// Widths and field positions
// ************************************************************
`define WORD_W        16
`define PAGE_W        7
`define PTR_W         23
`define PAGE_MSB      22
`define PAGE_LSB      16
`define LOW_MSB       15
`define ASM_W         5
`define MMR_AW        7
`define PTR_SEL_W     4
`define COEF_PAGE_MSB 6

// ************************************************************
// Memory-mapped word addresses
// ************************************************************
`define ADDR_AUX_LOW_BASE 7'h10
`define ADDR_COEF_LOW     7'h18
`define ADDR_TEMP_BASE    7'h20
`define ADDR_CIRC_START   7'h32
`define ADDR_COEF_PAGE    7'h4F

// ************************************************************
// Selectors and reset values
// ************************************************************
`define COEF_SEL      4'h8
`define CIRC_COEF_IDX 3'h4
`define WORD_RST      16'h0000
`define PAGE_RST      7'h00
`define PTR_RST       23'h0_0000

`endif

// [hdl/dap_pkg.sv]
// Types shared by the pointer register file and its address generators
`include "dap_regs.svh"
package dap_pkg;

  // ************************************************************
  // Address-unit ALU operations on auxiliary pointer low parts
  // ************************************************************
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_AND = 3'h2,
    ALU_OR  = 3'h3,
    ALU_XOR = 3'h4,
    ALU_SHL = 3'h5,
    ALU_SHR = 3'h6
  } alu_op_t;

  // ************************************************************
  // Request carriers
  // ************************************************************
  typedef struct packed {
    logic                    en;
    logic [`PTR_SEL_W-1:0]   sel;
    logic [`PTR_W-1:0]       data;
  } ext_wr_t;

  typedef struct packed {
    logic                    en;
    logic [`PTR_SEL_W-1:0]   sel;
    logic [`WORD_W-1:0]      data;
  } low_wr_t;

  typedef struct packed {
    logic                    en;
    logic [1:0]              idx;
    logic [`WORD_W-1:0]      data;
  } tmp_wr_t;

  typedef struct packed {
    logic                    en;
    logic [2:0]              ar;
    logic [1:0]              t;
  } swap_t;

  typedef struct packed {
    logic                    en;
    logic [2:0]              ar;
    alu_op_t                 op;
    logic [`WORD_W-1:0]      operand;
  } alu_req_t;

  typedef struct packed {
    logic                    en;
    logic [`PTR_SEL_W-1:0]   sel;
    logic [`WORD_W-1:0]      step;
    logic                    low_only;
  } dag_req_t;

  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`MMR_AW-1:0]      addr;
    logic [`WORD_W-1:0]      wdata;
  } mmr_req_t;

  typedef struct packed {
    logic                    en;
    logic [`PTR_SEL_W-1:0]   sel;
  } agen_req_t;

endpackage : dap_pkg

// [hdl/ptr_addr_gen.sv]
// One operand address generator: linear or circular effective address
`timescale 1ns/1ps
`include "dap_regs.svh"
module ptr_addr_gen (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Request
  input  wire logic                req,
  input  wire logic [`PTR_W-1:0]   ptr,
  input  wire logic [`WORD_W-1:0]  start,
  input  wire logic                circ,
  // Result
  output logic      [`PTR_W-1:0]   addr_ff,
  output logic                     valid_ff
);

  // ************************************************************
  // Address forming
  // ************************************************************
  // Circular sum stays inside the pointer's own page by design
  logic [`WORD_W-1:0] circ_low;
  logic [`PTR_W-1:0]  nxt_addr;
  assign circ_low = ptr[`LOW_MSB:0] + start;
  assign nxt_addr = circ ? {ptr[`PAGE_MSB:`PAGE_LSB], circ_low} : ptr;

  // Result register, valid pulses one cycle per request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_ff  <= `PTR_RST;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= req;
      if (req) begin
        addr_ff <= nxt_addr;
      end
    end
  end

endmodule : ptr_addr_gen

// [bench/dap_checker.sv]
// Port-level assertions for the pointer register file
`timescale 1ns/1ps
module dap_checker #(
  parameter int AGEN_COUNT = 3
) (
  // Clock and reset
  input wire logic                           sys_clk,
  input wire logic                           rst,
  // Requests
  input wire dap_pkg::ext_wr_t               ext_wr,
  input wire dap_pkg::low_wr_t               low_wr,
  input wire dap_pkg::tmp_wr_t               tmp_wr,
  input wire dap_pkg::swap_t                 swap_req,
  input wire dap_pkg::alu_req_t              alu_req,
  input wire dap_pkg::dag_req_t              dag_req,
  input wire dap_pkg::mmr_req_t              mmr_req,
  input wire dap_pkg::agen_req_t [AGEN_COUNT-1:0] agen_req,
  input wire logic                           legacy_compat_mode,
  input wire logic [8:0]                     circ_cfg,
  // Results
  input wire logic [15:0]                    mmr_rdata_ff,
  input wire logic                           mmr_hit_ff,
  input wire logic                           asm_wr_ff,
  input wire logic [4:0]                     asm_wdata_ff,
  input wire logic [AGEN_COUNT-1:0][22:0]    agen_addr_ff,
  input wire logic [AGEN_COUNT-1:0]          agen_valid_ff,
  input wire logic [7:0][22:0]               ext_aux_ptr_ff,
  input wire logic [22:0]                    ext_coef_ptr_ff,
  input wire logic [4:0][15:0]               circ_start_ff
);
  import dap_pkg::*;
  // Stronger writers mask a step, so steps are judged alone
  wire        idle = !ext_wr.en && !low_wr.en && !swap_req.en && !alu_req.en && !mmr_req.wr;
  wire [22:0] full = ext_aux_ptr_ff[0] + {{7{dag_req.step[15]}}, dag_req.step};
  wire [15:0] low  = ext_aux_ptr_ff[0][15:0] + dag_req.step;
  wire [15:0] csum = ext_coef_ptr_ff[15:0] + circ_start_ff[4];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_rd(a);
    mmr_req.rd && mmr_req.addr == a;
  endsequence
  sequence s_step0(lo);
    idle && dag_req.en && dag_req.sel == 4'h0 && dag_req.low_only == lo;
  endsequence
  a_ext_aux_load: assert property (ext_wr.en && ext_wr.sel < 4'h8 |=>
    ext_aux_ptr_ff[$past(ext_wr.sel[2:0])] == $past(ext_wr.data)) else $error("pointer not loaded whole");
  a_step_full: assert property (s_step0(1'b0) |=> ext_aux_ptr_ff[0] == $past(full))
    else $error("full step wrong");
  a_step_low_wrap: assert property (s_step0(1'b1) |=>
    ext_aux_ptr_ff[0] == {$past(ext_aux_ptr_ff[0][22:16]), $past(low)}) else $error("low step wrong");
  a_start_read: assert property (s_rd(7'h32) |=> mmr_hit_ff && mmr_rdata_ff == $past(circ_start_ff[0]))
    else $error("start read wrong");
  a_page_read: assert property (s_rd(7'h4F) |=> mmr_rdata_ff == {9'h0, $past(ext_coef_ptr_ff[22:16])})
    else $error("page read wrong");
  a_coef_circ: assert property (agen_req[0].en && agen_req[0].sel == 4'h8 && circ_cfg[8] |=>
    agen_valid_ff[0] && agen_addr_ff[0] == {$past(ext_coef_ptr_ff[22:16]), $past(csum)}) else $error("circ addr");
  a_aux_linear: assert property (agen_req[0].en && agen_req[0].sel == 4'h1 && !circ_cfg[1] |=>
    agen_addr_ff[0] == $past(ext_aux_ptr_ff[1])) else $error("linear addr");
  a_compat_t2: assert property (legacy_compat_mode && tmp_wr.en && tmp_wr.idx == 2'h2 |=>
    asm_wr_ff && asm_wdata_ff == $past(tmp_wr.data[4:0])) else $error("shift field write lost");
endmodule : dap_checker

bind data_address_pointer_regs dap_checker #(.AGEN_COUNT(AGEN_COUNT)) chk (.*);

// [bench/cpu_req_model.sv]
// Instruction-side requester standing in for the decoder and address units
`timescale 1ns/1ps
module cpu_req_model (
  // Clock
  input wire logic                  sys_clk,
  // Requests toward the register file
  output dap_pkg::ext_wr_t          ext_wr,
  output dap_pkg::tmp_wr_t          tmp_wr,
  output dap_pkg::swap_t            swap_req,
  output dap_pkg::alu_req_t         alu_req,
  output dap_pkg::dag_req_t         dag_req,
  output dap_pkg::mmr_req_t         mmr_req,
  output dap_pkg::agen_req_t [2:0]  agen_req
);
  import dap_pkg::*;
  // Each request stands for one rising edge
  initial {ext_wr, tmp_wr, swap_req, alu_req, dag_req, mmr_req, agen_req} = '0;
  task automatic ext(input logic [3:0] s, input logic [22:0] d);
    @(negedge sys_clk) ext_wr <= {1'b1, s, d};
    @(negedge sys_clk) ext_wr <= '0;
  endtask : ext
  task automatic mmr(input logic w, r, input logic [6:0] a, input logic [15:0] d);
    @(negedge sys_clk) mmr_req <= {w, r, a, d};
    @(negedge sys_clk) mmr_req <= '0;
  endtask : mmr
  task automatic agen(input logic [3:0] s);
    @(negedge sys_clk) agen_req <= {3{1'b1, s}};
    @(negedge sys_clk) agen_req <= '0;
  endtask : agen
  task automatic dag(input logic [15:0] st, input logic lo);
    @(negedge sys_clk) dag_req <= {1'b1, 4'h0, st, lo};
    @(negedge sys_clk) dag_req <= '0;
  endtask : dag
  task automatic tmp(input logic [1:0] i, input logic [15:0] d);
    @(negedge sys_clk) tmp_wr <= {1'b1, i, d};
    @(negedge sys_clk) tmp_wr <= '0;
  endtask : tmp
  task automatic swap(input logic [2:0] a, input logic [1:0] t);
    @(negedge sys_clk) swap_req <= {1'b1, a, t};
    @(negedge sys_clk) swap_req <= '0;
  endtask : swap
  task automatic alu(input logic [2:0] a, input alu_op_t o, input logic [15:0] d);
    @(negedge sys_clk) alu_req <= {1'b1, a, o, d};
    @(negedge sys_clk) alu_req <= '0;
  endtask : alu
endmodule : cpu_req_model

// [bench/test_data_address_pointer_regs.sv]
// Self-checking bench for the pointer register file
`timescale 1ns/1ps
module test_data_address_pointer_regs;
  import dap_pkg::*;
  // Stimulus levels, requests and observed results
  logic sys_clk = 1'b0, rst = 1'b1, legacy_compat_mode = 1'b0;
  logic [4:0] acc_shift_mode_field = 5'h00;
  logic [8:0] circ_cfg = 9'h000;
  ext_wr_t ext_wr; tmp_wr_t tmp_wr; swap_t swap_req; dag_req_t dag_req; mmr_req_t mmr_req;
  agen_req_t [2:0] agen_req;
  wire low_wr_t low_wr = '0;
  alu_req_t alu_req;
  logic [15:0] mmr_rdata_ff; logic mmr_hit_ff, asm_wr_ff; logic [4:0] asm_wdata_ff;
  logic [2:0][22:0] agen_addr_ff; logic [2:0] agen_valid_ff; logic [3:0][15:0] temp_regs_ff;
  logic [7:0][22:0] ext_aux_ptr_ff; logic [22:0] ext_coef_ptr_ff; logic [4:0][15:0] circ_start_ff;
  int errors = 0, tests_run = 0;
  // Rows: pointer, start word, circular flag, expected operand address
  logic [3:0]  r_sel [6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h7, 4'h8};
  logic [22:0] r_ptr [6] = '{23'h12_FFF0, 23'h05_1234, 23'h7F_0001, 23'h01_8000, 23'h40_0003, 23'h2A_FFFF};
  logic [15:0] r_st [6] = '{16'h0020, 16'h0100, 16'h1111, 16'h8000, 16'h0005, 16'h0001};
  logic        r_circ [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic [22:0] r_exp [6] = '{23'h12_0010, 23'h05_1234, 23'h7F_1112, 23'h01_0000, 23'h40_0008, 23'h2A_0000};
  logic [6:0]  ra;
  data_address_pointer_regs DUT (.*);
  cpu_req_model partner (.*);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk_addr(input string n, input logic [22:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk_addr
  task automatic chk_word(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task automatic report_and_stop();
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    // Table: start word, pointer, operand address
    for (int i = 0; i < 6; i++) begin
      ra = (r_sel[i] > 4'h7) ? 7'h36 : 7'h32 + 7'(r_sel[i] >> 1);
      partner.mmr(1'b1, 1'b0, ra, r_st[i]);
      partner.ext(r_sel[i], r_ptr[i]);
      chk_addr("ptr", r_ptr[i], (r_sel[i] > 4'h7) ? ext_coef_ptr_ff : ext_aux_ptr_ff[r_sel[i][2:0]]);
      circ_cfg[r_sel[i]] = r_circ[i];
      partner.agen(r_sel[i]);
      chk_addr("agen", r_exp[i], agen_addr_ff[0]);
      chk_addr("ag2", r_exp[i], agen_addr_ff[2]);
      partner.mmr(1'b0, 1'b1, ra, 16'h0000);
      chk_word("start", r_st[i], mmr_rdata_ff);
      circ_cfg = 9'h000;
    end
    // Mid-run reset
    @(negedge sys_clk) rst = 1'b1;
    repeat (12) @(negedge sys_clk);
    chk_word("rst", 16'h0000, circ_start_ff[1]);
    rst = 1'b0;
    // Page crossing, dropped carry and low-only wrap
    partner.ext(4'h0, 23'h00_FFFF);
    partner.dag(16'h0001, 1'b0);
    chk_addr("cross", 23'h01_0000, ext_aux_ptr_ff[0]);
    partner.ext(4'h0, 23'h7F_FFFF);
    partner.dag(16'h0001, 1'b0);
    chk_addr("carry", 23'h00_0000, ext_aux_ptr_ff[0]);
    partner.ext(4'h0, 23'h03_FFFF);
    partner.dag(16'h0001, 1'b1);
    chk_addr("wrap", 23'h03_0000, ext_aux_ptr_ff[0]);
    // Coefficient page read and write, unmapped word
    partner.ext(4'h8, 23'h55_0000);
    partner.mmr(1'b0, 1'b1, 7'h4F, 16'h0000);
    chk_word("page", 16'h0055, mmr_rdata_ff);
    partner.mmr(1'b1, 1'b0, 7'h4F, 16'hFF2A);
    chk_addr("pagew", 23'h2A_0000, ext_coef_ptr_ff);
    partner.mmr(1'b0, 1'b1, 7'h50, 16'h0000);
    chk_word("miss", 16'h0000, {15'h0000, mmr_hit_ff});
    // Low part by map keeps page; swap with a temporary register
    partner.mmr(1'b1, 1'b0, 7'h10, 16'hBEEF);
    chk_addr("lowmap", 23'h03_BEEF, ext_aux_ptr_ff[0]);
    partner.tmp(2'h1, 16'h1234);
    partner.swap(3'h0, 2'h1);
    chk_word("swap_t", 16'hBEEF, temp_regs_ff[1]);
    chk_addr("swap_a", 23'h03_1234, ext_aux_ptr_ff[0]);
    partner.alu(3'h0, ALU_SHL, 16'h0004);
    chk_addr("alu", 23'h03_2340, ext_aux_ptr_ff[0]);
    // Compat mode: start words are still zero after the reset above
    legacy_compat_mode = 1'b1;
    acc_shift_mode_field = 5'h13;
    partner.tmp(2'h2, 16'h0007);
    chk_word("t2", 16'hFFF3, temp_regs_ff[2]);
    chk_word("asm", 16'h0007, {11'h000, asm_wdata_ff});
    report_and_stop();
  end
endmodule : test_data_address_pointer_regs
